// File: dfcwl_consts.vh
// Constants for the frequency change and write leveling block
`ifndef DFCWL_CONSTS_VH
`define DFCWL_CONSTS_VH
// APB register byte offsets
`define DFCWL_ADDR_MODE_ONE   12'h000
`define DFCWL_ADDR_MODE_ZERO  12'h004
`define DFCWL_ADDR_CMD        12'h008
`define DFCWL_ADDR_STATUS     12'h00c
// Mode register one fields
`define DFCWL_MODE_ONE_DLL_DIS   0
`define DFCWL_MODE_ONE_WLVL      7
`define DFCWL_MODE_ONE_QOFF      12
`define DFCWL_MODE_ONE_RTT_LO    2
`define DFCWL_MODE_ONE_RTT_MID   6
`define DFCWL_MODE_ONE_RTT_HI    9
// Mode register zero fields
`define DFCWL_MODE_ZERO_DLL_RST  8
// Command register bits (write one to act)
`define DFCWL_CMD_SELF_REFRESH_ENTER 0
`define DFCWL_CMD_SELF_REFRESH_EXIT  1
`define DFCWL_CMD_PD_ENTER    2
`define DFCWL_CMD_PD_EXIT     3
// Status register bits
`define DFCWL_ST_STATE_LSB    0
`define DFCWL_ST_CLK_IGN      3
`define DFCWL_ST_DLL_LOCKED   4
`define DFCWL_ST_DQS_TERM     5
`define DFCWL_ST_WLVL         6
`define DFCWL_ST_FB_LO        7
`define DFCWL_ST_FB_HI        8
`define DFCWL_ST_ODT_ERR      9
`define DFCWL_ST_CMD_BLOCK    10
// Reset values
`define DFCWL_MODE_ONE_RESET  32'h0000_0000
`define DFCWL_MODE_ZERO_RESET 32'h0000_0000
// Timing in ns and derived cycle counts at 25 MHz (40 ns)
`define DFCWL_CLK_PERIOD_NS   40
`define DFCWL_CLK_HOLD_NS     10
`define DFCWL_CLK_HOLD_CYC \
   ((`DFCWL_CLK_HOLD_NS + `DFCWL_CLK_PERIOD_NS - 1) / `DFCWL_CLK_PERIOD_NS)
`define DFCWL_EXIT_DELAY_NS   24
`define DFCWL_EXIT_DELAY_CYC \
   ((`DFCWL_EXIT_DELAY_NS + `DFCWL_CLK_PERIOD_NS - 1) / `DFCWL_CLK_PERIOD_NS)
`define DFCWL_DLLK_CYC        512
`define DFCWL_CNT_W           10
`endif

// File: dfcwl_sync3.v
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module dfcwl_sync3 (
   input  wire ref_clk_i,
   input  wire rst_i,
   input  wire ce_i,
   input  wire d_i,
   output reg  q_o,
   output reg  rise_o
);
   reg s1;
   reg s2;
   reg s3;

   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1     <= 1'b0;
         s2     <= 1'b0;
         s3     <= 1'b0;
         q_o    <= 1'b0;
         rise_o <= 1'b0;
      end else if (ce_i) begin
         s1     <= d_i;
         s2     <= s1;
         s3     <= s2;
         rise_o <= 1'b0;
         // Only a level seen by both later stages counts as a change
         if (s2 == s3) begin
            q_o    <= s3;
            rise_o <= s3 & ~q_o;
         end
      end
   end
endmodule

// File: dfcwl_top.v
// DRAM-side frequency change, DLL switch and write leveling logic
// Overview of operation
// - Clock ignored after entry hold time elapses
// - Termination off through powerdown if enabled, except strobe termination, which follows ODT in leveling
// - ODT low, CKE high during DLL relock; only ODT is checked, CKE is ignored
// - Strobe rising edge samples clock onto data
// - Lower lane on bit0, upper on bit8
// - Mode register one bit seven controls leveling
// - Bit twelve disables output buffers
// - ODT switches only strobe termination in leveling
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "dfcwl_consts.vh"
module dfcwl_top #(
   parameter DLLK_CYC = `DFCWL_DLLK_CYC
) (
   input  wire        ref_clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   input  wire        mem_clk_i,
   input  wire        odt_i,
   input  wire        cke_i,
   input  wire        dqs_lo_i,
   input  wire        dqs_hi_i,
   output reg  [15:0] dq_o,
   output reg  [15:0] dq_oe_o,
   output reg         dqs_term_en_o,
   output reg         dq_term_en_o,
   output reg         dll_locked_o,
   output reg         cmd_block_o
);
   localparam ST_IDLE         = 3'd0;
   localparam ST_SELF_REFRESH = 3'd1;
   localparam ST_PD           = 3'd2;
   localparam ST_EXIT         = 3'd3;
   localparam ST_RELOCK       = 3'd4;
   // Counts kept as full words and cut to the counter width where loaded
   localparam [31:0] HOLD_CYC = `DFCWL_CLK_HOLD_CYC;
   localparam [31:0] EXIT_CYC = `DFCWL_EXIT_DELAY_CYC;

   reg [31:0] mode_register_one;
   reg [31:0] mode_register_zero;
   reg [2:0]  state;
   reg [`DFCWL_CNT_W-1:0] cnt;
   reg        clk_ign;
   reg        rtt_at_entry;
   reg        odt_err;
   reg        fb_lo;
   reg        fb_hi;
   reg [31:0] next_prdata;

   wire clk_s;
   wire odt_s;
   wire cke_s;
   wire dqs_lo_s;
   wire dqs_hi_s;
   wire dqs_lo_rise;
   wire dqs_hi_rise;

   dfcwl_sync3 u_clk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
                      .d_i(mem_clk_i), .q_o(clk_s), .rise_o());
   dfcwl_sync3 u_odt (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
                      .d_i(odt_i), .q_o(odt_s), .rise_o());
   dfcwl_sync3 u_cke (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
                      .d_i(cke_i), .q_o(cke_s), .rise_o());
   dfcwl_sync3 u_dql (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
                      .d_i(dqs_lo_i), .q_o(dqs_lo_s), .rise_o(dqs_lo_rise));
   dfcwl_sync3 u_dqh (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i),
                      .d_i(dqs_hi_i), .q_o(dqs_hi_s), .rise_o(dqs_hi_rise));

   wire acc      = psel_i & penable_i & pready_o;
   wire wr       = acc & pwrite_i;
   wire hit_one  = (paddr_i == `DFCWL_ADDR_MODE_ONE);
   wire hit_zero = (paddr_i == `DFCWL_ADDR_MODE_ZERO);
   wire hit_cmd  = (paddr_i == `DFCWL_ADDR_CMD);
   wire hit_st   = (paddr_i == `DFCWL_ADDR_STATUS);
   wire mapped   = hit_one | hit_zero | hit_cmd | hit_st;
   wire wlvl     = mode_register_one[`DFCWL_MODE_ONE_WLVL];
   wire qoff     = mode_register_one[`DFCWL_MODE_ONE_QOFF];
   wire rtt_en   = mode_register_one[`DFCWL_MODE_ONE_RTT_LO] |
                   mode_register_one[`DFCWL_MODE_ONE_RTT_MID] |
                   mode_register_one[`DFCWL_MODE_ONE_RTT_HI];
   wire cmd_sre  = wr & hit_cmd & pwdata_i[`DFCWL_CMD_SELF_REFRESH_ENTER];
   wire cmd_srx  = wr & hit_cmd & pwdata_i[`DFCWL_CMD_SELF_REFRESH_EXIT];
   wire cmd_pde  = wr & hit_cmd & pwdata_i[`DFCWL_CMD_PD_ENTER];
   wire cmd_pdx  = wr & hit_cmd & pwdata_i[`DFCWL_CMD_PD_EXIT];
   // DLL reset is the write of mode register zero with bit eight high
   wire dll_rst  = wr & hit_zero & pwdata_i[`DFCWL_MODE_ZERO_DLL_RST];

   always @* begin
      next_prdata = 32'h0000_0000;
      if (hit_one)
         next_prdata = mode_register_one;
      else if (hit_zero)
         next_prdata = mode_register_zero;
      else if (hit_st) begin
         next_prdata[`DFCWL_ST_STATE_LSB+2:`DFCWL_ST_STATE_LSB] = state;
         next_prdata[`DFCWL_ST_CLK_IGN]    = clk_ign;
         next_prdata[`DFCWL_ST_DLL_LOCKED] = dll_locked_o;
         next_prdata[`DFCWL_ST_DQS_TERM]   = dqs_term_en_o;
         next_prdata[`DFCWL_ST_WLVL]       = wlvl;
         next_prdata[`DFCWL_ST_FB_LO]      = fb_lo;
         next_prdata[`DFCWL_ST_FB_HI]      = fb_hi;
         next_prdata[`DFCWL_ST_ODT_ERR]    = odt_err;
         next_prdata[`DFCWL_ST_CMD_BLOCK]  = cmd_block_o;
      end
   end

   // APB slave: one wait state, so every access ends two cycles after setup
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         mode_register_one  <= `DFCWL_MODE_ONE_RESET;
         mode_register_zero <= `DFCWL_MODE_ZERO_RESET;
      end else if (ce_i) begin
         pready_o  <= psel_i & penable_i & ~pready_o;
         pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
         if (psel_i & penable_i & ~pready_o)
            prdata_o <= pwrite_i ? 32'h0000_0000 : next_prdata;
         if (wr & hit_one)
            mode_register_one <= pwdata_i;
         if (wr & hit_zero)
            mode_register_zero <= pwdata_i;
      end
   end

   // Power state sequencer with clock-ignore and relock timing
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state        <= ST_IDLE;
         cnt          <= {`DFCWL_CNT_W{1'b0}};
         clk_ign      <= 1'b0;
         rtt_at_entry <= 1'b0;
         odt_err      <= 1'b0;
         dll_locked_o <= 1'b0;
         cmd_block_o  <= 1'b1;
      end else if (ce_i) begin
         if (dll_rst) begin
            state        <= ST_RELOCK;
            cnt          <= DLLK_CYC[`DFCWL_CNT_W-1:0] - 1'b1;
            dll_locked_o <= 1'b0;
            cmd_block_o  <= 1'b1;
         end else begin
            case (state)
               ST_IDLE: begin
                  if (cmd_sre | (cmd_pde & ~cke_s)) begin
                     state        <= cmd_sre ? ST_SELF_REFRESH : ST_PD;
                     rtt_at_entry <= rtt_en;
                     clk_ign      <= 1'b0;
                     cnt          <= HOLD_CYC[`DFCWL_CNT_W-1:0];
                  end
               end
               ST_SELF_REFRESH, ST_PD: begin
                  if (cnt != {`DFCWL_CNT_W{1'b0}})
                     cnt <= cnt - 1'b1;
                  else
                     clk_ign <= 1'b1;
                  // ODT must stay low through powerdown; flagged only if termination was on at entry
                  if (state == ST_PD && rtt_at_entry && odt_s)
                     odt_err <= 1'b1;
                  if ((state == ST_SELF_REFRESH && cmd_srx) || (state == ST_PD && cmd_pdx)) begin
                     clk_ign     <= 1'b0;
                     state       <= ST_EXIT;
                     cnt         <= EXIT_CYC[`DFCWL_CNT_W-1:0];
                     // DLL must relock after any frequency change
                     dll_locked_o <= 1'b0;
                     cmd_block_o  <= 1'b1;
                  end
               end
               ST_EXIT: begin
                  if (cnt != {`DFCWL_CNT_W{1'b0}})
                     cnt <= cnt - 1'b1;
               end
               ST_RELOCK: begin
                  if (odt_s)
                     odt_err <= 1'b1;
                  if (cnt != {`DFCWL_CNT_W{1'b0}})
                     cnt <= cnt - 1'b1;
                  else begin
                     state        <= ST_IDLE;
                     dll_locked_o <= ~mode_register_one[`DFCWL_MODE_ONE_DLL_DIS];
                     cmd_block_o  <= 1'b0;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // Write leveling feedback and termination steering
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fb_lo         <= 1'b0;
         fb_hi         <= 1'b0;
         dq_o          <= 16'h0000;
         dq_oe_o       <= 16'h0000;
         dqs_term_en_o <= 1'b0;
         dq_term_en_o  <= 1'b0;
      end else if (ce_i) begin
         if (wlvl & dqs_lo_rise)
            fb_lo <= clk_s;
         if (wlvl & dqs_hi_rise)
            fb_hi <= clk_s;
         // per-lane prime bits, others driven low
         dq_o     <= {7'h00, fb_hi, 7'h00, fb_lo};
         dq_oe_o  <= (wlvl & ~qoff) ? 16'hffff : 16'h0000;
         dqs_term_en_o <= wlvl ? odt_s : (odt_s & rtt_en & (state == ST_IDLE));
         dq_term_en_o  <= wlvl ? 1'b0 : (odt_s & rtt_en & (state == ST_IDLE));
      end
   end
endmodule

// File: dfcwl_checker.sv
// Pin-level checker for the frequency change and leveling block
`timescale 1ns/1ps
module dfcwl_checker (
   input wire        ref_clk_i,
   input wire        rst_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire        cke_i,
   input wire        dqs_lo_i,
   input wire [15:0] dq_o,
   input wire [15:0] dq_oe_o,
   input wire        dqs_term_en_o,
   input wire        dq_term_en_o,
   input wire        dll_locked_o,
   input wire        cmd_block_o
);
   reg [3:0] lo_age;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   // Saturating age of the last lower strobe rise
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i)
         lo_age <= 4'hf;
      else if ($rose(dqs_lo_i))
         lo_age <= 4'h0;
      else if (lo_age != 4'hf)
         lo_age <= lo_age + 4'h1;
   end
   sequence s_wait;
      psel_i && penable_i && !pready_o;
   endsequence
   sequence s_done;
      pready_o ##1 !pready_o;
   endsequence
   chk_ready_one: assert property (s_wait |=> s_done)
      else $error("ready not a single cycle after one wait");
   chk_err_ready: assert property (pslverr_o |-> pready_o)
      else $error("error flag without ready");
   chk_dq_spare: assert property ((dq_o & 16'hfefe) == 16'h0000)
      else $error("feedback on an unused data bit");
   chk_oe_whole: assert property (dq_oe_o == 16'h0000 || dq_oe_o == 16'hffff)
      else $error("data enables split");
   chk_dq_term: assert property (dq_oe_o[0] |-> !dq_term_en_o)
      else $error("data termination on while leveling");
   chk_lock_block: assert property (dll_locked_o |-> !cmd_block_o)
      else $error("locked but commands still blocked");
   chk_pd_term: assert property (!cke_i [*5] |-> !dqs_term_en_o && !dq_term_en_o)
      else $error("termination on in power down");
   chk_fb_cause: assert property ($changed(dq_o[0]) && $past(dq_oe_o[0]) && dq_oe_o[0]
      |-> lo_age <= 4'h8)
      else $error("feedback moved without a strobe");
endmodule
bind dfcwl_top dfcwl_checker u_dfcwl_checker (.ref_clk_i, .rst_i, .psel_i, .penable_i,
   .pready_o, .pslverr_o, .cke_i, .dqs_lo_i, .dq_o, .dq_oe_o, .dqs_term_en_o,
   .dq_term_en_o, .dll_locked_o, .cmd_block_o);

// File: dfcwl_ctrl_model.sv
// Controller-side model: memory clock, CKE, ODT and strobes
`timescale 1ns/1ps
module dfcwl_ctrl_model (
   input  wire ref_clk_i,
   output wire mem_clk_o,
   output reg  odt_o = 1'b0,
   output reg  cke_o = 1'b1,
   output reg  dqs_lo_o = 1'b0,
   output reg  dqs_hi_o = 1'b0
);
   reg [3:0] cnt = 4'h0;
   reg [1:0] sel = 2'h3;
   always @(posedge ref_clk_i) begin
      cnt <= cnt + 4'h1;
   end
   assign mem_clk_o = cnt[sel];
   task pins(input logic o, input logic c);
      begin
         odt_o <= o;
         cke_o <= c;
      end
   endtask
   task set_freq(input logic [1:0] s);
      begin
         pins(1'b0, 1'b0);
         repeat (4) @(posedge ref_clk_i);
         sel <= s;
         repeat (8) @(posedge ref_clk_i);
      end
   endtask
   // strobe rises d counts into the period
   task strobe(input logic hi, input logic [3:0] d);
      begin
         @(posedge ref_clk_i);
         while (cnt != d - 4'h1)
            @(posedge ref_clk_i);
         dqs_hi_o <= hi;
         dqs_lo_o <= !hi;
         repeat (3) @(posedge ref_clk_i);
         dqs_hi_o <= 1'b0;
         dqs_lo_o <= 1'b0;
      end
   endtask
endmodule

// File: dfcwl_top_test.sv
// Self-checking bench for the frequency change and leveling block
`timescale 1ns/1ps
`include "dfcwl_consts.vh"
module dfcwl_top_test;
   reg         ref_clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         ce_i = 1'b1;
   reg         psel_i = 1'b0;
   reg         penable_i = 1'b0;
   reg         pwrite_i = 1'b0;
   reg  [11:0] paddr_i = 12'h000;
   reg  [31:0] pwdata_i = 32'h0;
   wire [31:0] prdata_o;
   wire        pready_o, pslverr_o, mem_clk, odt, cke, dqs_lo, dqs_hi;
   wire [15:0] dq_o, dq_oe_o;
   wire        dqs_term_en_o, dq_term_en_o, dll_locked_o, cmd_block_o;
   reg  [31:0] rd;
   reg         er;
   reg  [3:0]  d;
   reg         hi;
   int         errors = 0;
   int         samples_checked = 0;
   dfcwl_top #(.DLLK_CYC(8)) u_dfcwl_top (.ref_clk_i, .rst_i, .ce_i, .psel_i,
      .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .mem_clk_i(mem_clk), .odt_i(odt), .cke_i(cke), .dqs_lo_i(dqs_lo), .dqs_hi_i(dqs_hi),
      .dq_o, .dq_oe_o, .dqs_term_en_o, .dq_term_en_o, .dll_locked_o, .cmd_block_o);
   dfcwl_ctrl_model u_dfcwl_ctrl_model (.ref_clk_i, .mem_clk_o(mem_clk), .odt_o(odt),
      .cke_o(cke), .dqs_lo_o(dqs_lo), .dqs_hi_o(dqs_hi));
   initial begin
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   // Clock is high in the second half of its count
   function logic fb(input logic [3:0] v);
      fb = v[3];
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task close_out;
      begin
         $display("checks %0d errors %0d", samples_checked, errors);
         if (errors == 0 && samples_checked > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      int n;
      begin
         n = 0;
         psel_i <= 1'b1;
         pwrite_i <= w;
         paddr_i <= a;
         pwdata_i <= v;
         @(posedge ref_clk_i);
         penable_i <= 1'b1;
         @(posedge ref_clk_i);
         while (pready_o !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge ref_clk_i);
         end
         if (n == 20)
            errors = errors + 1;
         rd = prdata_o;
         er = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
         @(posedge ref_clk_i);
      end
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
      begin
         apb(1'b0, a, 32'h0);
         check(rd & m, x);
      end
   endtask
   task level(input logic h, input logic [3:0] v);
      begin
         u_dfcwl_ctrl_model.strobe(h, v);
         repeat (6) @(posedge ref_clk_i);
         check(32'(h ? dq_o[8] : dq_o[0]), 32'(fb(v)));
         check(32'(dq_o & 16'hfefe), 32'h0);
      end
   endtask
   initial begin
      #800000;
      errors = errors + 1;
      close_out;
   end
   initial begin
      void'($urandom(32'h43dec245));
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      rdchk(`DFCWL_ADDR_MODE_ONE, 32'hffffffff, `DFCWL_MODE_ONE_RESET);
      rdchk(`DFCWL_ADDR_STATUS, 32'h7ff, 32'h400);
      apb(1'b0, 12'h010, 32'h0);
      check(32'(er), 32'h1);
      check(rd, 32'h0);
      apb(1'b1, `DFCWL_ADDR_CMD, 32'h1);
      rdchk(`DFCWL_ADDR_STATUS, 32'hf, 32'h9);
      u_dfcwl_ctrl_model.set_freq(2'h2);
      u_dfcwl_ctrl_model.pins(1'b0, 1'b1);
      apb(1'b1, `DFCWL_ADDR_CMD, 32'h2);
      apb(1'b1, `DFCWL_ADDR_MODE_ONE, 32'h0);
      apb(1'b1, `DFCWL_ADDR_MODE_ZERO, 32'h100);
      repeat (16) @(posedge ref_clk_i);
      check(32'(dll_locked_o), 32'h1);
      // Power-down route back to the first rate
      u_dfcwl_ctrl_model.pins(1'b0, 1'b0);
      repeat (4) @(posedge ref_clk_i);
      apb(1'b1, `DFCWL_ADDR_CMD, 32'h4);
      rdchk(`DFCWL_ADDR_STATUS, 32'hf, 32'ha);
      u_dfcwl_ctrl_model.set_freq(2'h3);
      u_dfcwl_ctrl_model.pins(1'b0, 1'b1);
      apb(1'b1, `DFCWL_ADDR_CMD, 32'h8);
      apb(1'b1, `DFCWL_ADDR_MODE_ZERO, 32'h100);
      check(32'({dll_locked_o, cmd_block_o}), 32'h1);
      // Enable low must freeze the relock count
      ce_i <= 1'b0;
      repeat (16) @(posedge ref_clk_i);
      check(32'({dll_locked_o, cmd_block_o}), 32'h1);
      ce_i <= 1'b1;
      repeat (16) @(posedge ref_clk_i);
      check(32'({dll_locked_o, cmd_block_o}), 32'h2);
      // Leveling with a termination value allowed while outputs drive
      apb(1'b1, `DFCWL_ADDR_MODE_ONE, 32'h84);
      // Enables follow the mode write one register stage later
      @(posedge ref_clk_i);
      check(32'(dq_oe_o), 32'hffff);
      rdchk(`DFCWL_ADDR_STATUS, 32'h40, 32'h40);
      u_dfcwl_ctrl_model.pins(1'b1, 1'b1);
      repeat (6) @(posedge ref_clk_i);
      check(32'({dqs_term_en_o, dq_term_en_o}), 32'h2);
      u_dfcwl_ctrl_model.pins(1'b0, 1'b1);
      repeat (6) @(posedge ref_clk_i);
      check(32'({dqs_term_en_o, dq_term_en_o}), 32'h0);
      for (int i = 1; i < 15; i++) begin
         if (i != 7 && i != 8)
            level(1'b0, 4'(i));
      end
      repeat (8) begin
         d = 4'($urandom_range(1, 12));
         hi = 1'($urandom);
         level(hi, d > 4'h6 ? d + 4'h2 : d);
      end
      apb(1'b1, `DFCWL_ADDR_MODE_ONE, 32'h1084);
      @(posedge ref_clk_i);
      check(32'(dq_oe_o), 32'h0);
      apb(1'b1, `DFCWL_ADDR_MODE_ONE, 32'h0);
      rdchk(`DFCWL_ADDR_STATUS, 32'h40, 32'h0);
      // Termination enabled, then ODT raised in power down on purpose
      apb(1'b1, `DFCWL_ADDR_MODE_ONE, 32'h4);
      u_dfcwl_ctrl_model.pins(1'b0, 1'b0);
      repeat (4) @(posedge ref_clk_i);
      apb(1'b1, `DFCWL_ADDR_CMD, 32'h4);
      u_dfcwl_ctrl_model.pins(1'b1, 1'b0);
      repeat (6) @(posedge ref_clk_i);
      rdchk(`DFCWL_ADDR_STATUS, 32'h200, 32'h200);
      check(32'(dqs_term_en_o), 32'h0);
      rst_i <= 1'b1;
      u_dfcwl_ctrl_model.pins(1'b0, 1'b1);
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      rdchk(`DFCWL_ADDR_STATUS, 32'h610, 32'h400);
      close_out;
   end
endmodule
